// *** rtl/intr_pkg.sv ***
package intr_pkg;

	// ****************************************************
	// register map, byte index on the plain port
	// ****************************************************
	localparam int unsigned AW = 3;
	localparam logic [AW-1:0] ADDR_IEN1 = 3'h0;
	localparam logic [AW-1:0] ADDR_IEN2 = 3'h1;
	localparam logic [AW-1:0] ADDR_INT_REQ_REG1 = 3'h2;
	localparam logic [AW-1:0] ADDR_INT_REQ_REG2 = 3'h3;
	localparam logic [AW-1:0] ADDR_WAKE_FLAG = 3'h4;
	localparam logic [AW-1:0] ADDR_WAKE_EDGE = 3'h5;
	localparam logic [AW-1:0] ADDR_EXT_EDGE = 3'h6;
	localparam logic [AW-1:0] ADDR_CCR = 3'h7;

	// ****************************************************
	// field positions
	// ****************************************************
	localparam int unsigned IEN1_WAKE_BIT = 5;
	localparam int unsigned INT_REQ_REG1_ONE_BIT = 5;
	localparam int unsigned INT_REQ_REG1_TA_BIT = 7;
	localparam int unsigned INT_REQ_REG1_S1_BIT = 6;
	localparam int unsigned INT_REQ_REG2_DT_BIT = 7;
	localparam int unsigned INT_REQ_REG2_AD_BIT = 6;
	localparam int unsigned INT_REQ_REG2_TG_BIT = 4;
	localparam int unsigned INT_REQ_REG2_TFH_BIT = 3;
	localparam int unsigned INT_REQ_REG2_TFL_BIT = 2;
	localparam int unsigned INT_REQ_REG2_TC_BIT = 1;
	localparam int unsigned INT_REQ_REG2_EC_BIT = 0;
	localparam int unsigned CCR_I_BIT = 7;
	localparam int unsigned N_EXT = 5;
	localparam int unsigned N_WAKE = 8;

	// ****************************************************
	// reset values and vectors
	// ****************************************************
	localparam logic [7:0] WAKE_EDGE_RST = 8'h00;
	localparam logic [7:0] INT_REQ_REG1_ONE_MASK = 8'h20;
	localparam logic [7:0] CNT_ONES = 8'hFF;
	localparam logic [7:0] CNT_ZERO = 8'h00;
	localparam int unsigned N_SRC = 17;
	localparam logic [4:0] VEC_EXT_BASE = 5'h04;
	localparam logic [4:0] VEC_WAKE = 5'h09;
	localparam logic [4:0] VEC_INT_LO = 5'h0A;
	localparam logic [4:0] VEC_INT_HI = 5'h14;

	// ****************************************************
	// acceptance sequence lengths in states, and the stack count for the condition code push
	// ****************************************************
	localparam logic [3:0] STACK_STATES = 4'h4;
	localparam logic [3:0] VFETCH_STATES = 4'h2;
	localparam logic [3:0] IFETCH_STATES = 4'h4;
	localparam logic [3:0] CCR_PUSH_CNT = 4'h2;

	typedef enum logic [1:0] {ST_IDLE, ST_STACK, ST_VECT, ST_FETCH} seq_t;

endpackage

// *** rtl/pin_edge_det.sv ***
// two-stage synchroniser and selectable edge detector per pin
module pin_edge_det #(
	parameter int W = 8
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [W-1:0] pin,
	input wire logic [W-1:0] rise_sel,
	output logic [W-1:0] edge_pulse
);
	typedef struct packed {
		logic [W-1:0] sync1;
		logic [W-1:0] sync2;
		logic [W-1:0] prev;
		logic [2:0] prime;
		logic [W-1:0] pulse;
	} det_t;

	det_t st;
	det_t nx;

	// prime holds off pulses until prev carries a real pin level
	always_comb
	begin
		nx = st;
		nx.sync1 = pin;
		nx.sync2 = st.sync1;
		nx.prev = st.sync2;
		nx.prime = {st.prime[1:0], 1'b1};
		nx.pulse = '0;
		if (st.prime[2])
		begin
			nx.pulse = (rise_sel & st.sync2 & ~st.prev)
				| (~rise_sel & ~st.sync2 & st.prev);
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
			st <= '0;
		else
			st <= nx;
	end

	assign edge_pulse = st.pulse;
endmodule

// *** rtl/count_wrap_det.sv ***
// flags a counter stepping all ones to zero or zero to all ones
module count_wrap_det #(
	parameter int W = 8
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [W-1:0] count,
	output logic up_wrap,
	output logic down_wrap
);
	typedef struct packed {
		logic [W-1:0] prev;
		logic primed;
		logic up;
		logic down;
	} wrap_t;

	wrap_t st;
	wrap_t nx;

	// count is on this clock, so no synchroniser is needed
	always_comb
	begin
		nx = st;
		nx.prev = count;
		nx.primed = 1'b1;
		nx.up = st.primed && (&st.prev) && (count == '0);
		nx.down = st.primed && (st.prev == '0) && (&count);
	end

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
			st <= '0;
		else
			st <= nx;
	end

	assign up_wrap = st.up;
	assign down_wrap = st.down;
endmodule

// *** rtl/intr_ctrl.sv ***
// Contract
// - timer C flag sets on counter wrap FF to 00 or 00 to FF
// - event flag: high byte overflow in 16-bit, either byte in 8-bit mode
// - flags survive acceptance, clear by writing 0, writing 1 does nothing
// - wakeup flag sets on selected edge when pin has wakeup function
// - wakeup edge bit 0 falling, 1 rising, register resets to zero
// - each external pin has its own edge select bit
// - external pin edge with interrupt function sets its request flag
// - one group enable gates all eight wakeup requests
// - each external pin request has its own enable bit
// - internal sources have flags and matching enable bits
// - mask bit set holds every maskable request pending
// - all wakeup sources share vector 9
// - external pins 4 to 0 use vectors 8 to 4, pin 0 first
// - internal sources use vectors 20 down to 10; the code's nine internal sources use vectors 10 to 18 only
// - source raises a request only while enabled, then flag sets
// - highest priority request selected, others stay pending
// - selected request accepted only when mask bit is 0
// - after instruction ends, push return PC then condition code
// - acceptance sets the mask bit
// - vector address generated, handler address fetched and started
// - clear colliding with a request still leaves that interrupt taken
// - stacking 4 states, vector fetch 2, instruction fetch 4
module intr_ctrl (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [7:0] wakeup_pin,
	input wire logic [7:0] wakeup_pin_func,
	input wire logic [4:0] ext_req_pin,
	input wire logic [4:0] ext_pin_func,
	input wire logic [7:0] timer_c_count,
	input wire logic [7:0] event_ctr_high,
	input wire logic [7:0] event_ctr_low,
	input wire logic event_ctr_16bit,
	input wire logic [6:0] periph_req,
	input wire logic instr_done,
	input wire logic [15:0] next_pc,
	input wire logic [6:0] ccr_flags,
	input wire logic [15:0] vector_data,
	output logic cpu_mask,
	output logic stack_wr,
	output logic [15:0] stack_data,
	output logic vector_rd,
	output logic [15:0] vector_addr,
	output logic fetch_rd,
	output logic [15:0] fetch_addr,
	output logic handler_start,
	output logic [4:0] accept_vector
);
	typedef struct packed {
		logic [7:0] ien1;
		logic [7:0] ien2;
		logic [7:0] int_req_reg1;
		logic [7:0] int_req_reg2;
		logic [7:0] wflag;
		logic [7:0] wedge;
		logic [4:0] eedge;
		logic i_bit;
		intr_pkg::seq_t seq;
		logic [3:0] cnt;
		logic [4:0] vec;
		logic [7:0] saved_ccr;
		logic [7:0] rdata;
		logic stack_wr;
		logic [15:0] stack_data;
		logic vector_rd;
		logic [15:0] vector_addr;
		logic fetch_rd;
		logic [15:0] fetch_addr;
		logic handler_start;
	} ctrl_t;

	ctrl_t st;
	ctrl_t nx;

	logic [7:0] wake_edge;
	logic [4:0] ext_edge;
	logic tc_up;
	logic tc_down;
	logic ech_up;
	logic ecl_up;
	logic [4:0] ext_set;
	logic [7:0] wake_set;
	logic [7:0] int_req_reg1_set;
	logic [7:0] int_req_reg2_set;
	logic [16:0] pend;
	logic [4:0] prio_vec;
	logic accept;
	logic [7:0] rd_mux;
	logic wr_int_req_reg1;
	logic wr_int_req_reg2;
	logic wr_wflag;

	// ****************************************************
	// pin edges and counter wraps
	// ****************************************************
	// wakeup edge polarity
	pin_edge_det #(.W(intr_pkg::N_WAKE)) u_wake_edge (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.pin(wakeup_pin),
		.rise_sel(st.wedge),
		.edge_pulse(wake_edge)
	);

	pin_edge_det #(.W(intr_pkg::N_EXT)) u_ext_edge (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.pin(ext_req_pin),
		.rise_sel(st.eedge),
		.edge_pulse(ext_edge)
	);

	count_wrap_det #(.W(8)) u_tc_wrap (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.count(timer_c_count),
		.up_wrap(tc_up),
		.down_wrap(tc_down)
	);

	// the event counter only counts up, so down wraps are unused
	count_wrap_det #(.W(8)) u_ech_wrap (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.count(event_ctr_high),
		.up_wrap(ech_up),
		.down_wrap()
	);

	count_wrap_det #(.W(8)) u_ecl_wrap (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.count(event_ctr_low),
		.up_wrap(ecl_up),
		.down_wrap()
	);

	// ****************************************************
	// flag set terms
	// ****************************************************
	// external request with pin function and enable
	assign ext_set = ext_edge & ext_pin_func & st.ien1[4:0];
	// group enable gates all wakeup pins
	assign wake_set = wake_edge & wakeup_pin_func
		& {intr_pkg::N_WAKE{st.ien1[intr_pkg::IEN1_WAKE_BIT]}};

	// internal requests only pass while enabled
	always_comb
	begin
		int_req_reg1_set = '0;
		int_req_reg2_set = '0;
		int_req_reg1_set[4:0] = ext_set;
		int_req_reg1_set[intr_pkg::INT_REQ_REG1_TA_BIT] = periph_req[6];
		int_req_reg1_set[intr_pkg::INT_REQ_REG1_S1_BIT] = periph_req[5];
		int_req_reg2_set[intr_pkg::INT_REQ_REG2_DT_BIT] = periph_req[4];
		int_req_reg2_set[intr_pkg::INT_REQ_REG2_AD_BIT] = periph_req[3];
		int_req_reg2_set[intr_pkg::INT_REQ_REG2_TG_BIT] = periph_req[2];
		int_req_reg2_set[intr_pkg::INT_REQ_REG2_TFH_BIT] = periph_req[1];
		int_req_reg2_set[intr_pkg::INT_REQ_REG2_TFL_BIT] = periph_req[0];
		int_req_reg2_set[intr_pkg::INT_REQ_REG2_TC_BIT] = tc_up | tc_down;
		// event counter overflow by counting mode
		int_req_reg2_set[intr_pkg::INT_REQ_REG2_EC_BIT] = ech_up
			| (!event_ctr_16bit && ecl_up);
		int_req_reg1_set[7:5] = int_req_reg1_set[7:5] & st.ien1[7:5];
		int_req_reg2_set = int_req_reg2_set & st.ien2;
	end

	// ****************************************************
	// priority selection
	// ****************************************************
	// each flag is gated by its own enable bit, except the wakeup flags, which share the group enable
	always_comb
	begin
		pend = '0;
		// pins 0 to 4 take vectors 4 to 8
		pend[4:0] = st.int_req_reg1[4:0] & st.ien1[4:0];
		pend[5] = (|st.wflag) & st.ien1[intr_pkg::IEN1_WAKE_BIT];
		// internal sources fill vectors 10 upward
		pend[6] = st.int_req_reg2[7] & st.ien2[7];
		pend[7] = st.int_req_reg1[7] & st.ien1[7];
		pend[8] = st.int_req_reg1[6] & st.ien1[6];
		pend[9] = st.int_req_reg2[1] & st.ien2[1];
		pend[10] = st.int_req_reg2[0] & st.ien2[0];
		pend[11] = st.int_req_reg2[2] & st.ien2[2];
		pend[12] = st.int_req_reg2[3] & st.ien2[3];
		pend[13] = st.int_req_reg2[4] & st.ien2[4];
		pend[14] = st.int_req_reg2[6] & st.ien2[6];
	end

	// one winner, the rest stay pending
	// lowest vector wins; scan from the top down
	always_comb
	begin
		prio_vec = intr_pkg::VEC_EXT_BASE;
		for (int i = intr_pkg::N_SRC - 1; i >= 0; i--)
		begin
			if (pend[i])
				prio_vec = intr_pkg::VEC_EXT_BASE + 5'(i);
		end
	end

	// mask bit holds every request pending
	// accept only unmasked, at an instruction boundary
	assign accept = (st.seq == intr_pkg::ST_IDLE) && (|pend)
		&& !st.i_bit && instr_done;

	// ****************************************************
	// register port
	// ****************************************************
	assign wr_int_req_reg1 = reg_wr && (reg_addr == intr_pkg::ADDR_INT_REQ_REG1);
	assign wr_int_req_reg2 = reg_wr && (reg_addr == intr_pkg::ADDR_INT_REQ_REG2);
	assign wr_wflag = reg_wr && (reg_addr == intr_pkg::ADDR_WAKE_FLAG);

	// the forced one in the first request register is never stored
	always_comb
	begin
		case (reg_addr)
			intr_pkg::ADDR_IEN1: rd_mux = st.ien1;
			intr_pkg::ADDR_IEN2: rd_mux = st.ien2;
			intr_pkg::ADDR_INT_REQ_REG1: rd_mux = st.int_req_reg1 | intr_pkg::INT_REQ_REG1_ONE_MASK;
			intr_pkg::ADDR_INT_REQ_REG2: rd_mux = st.int_req_reg2;
			intr_pkg::ADDR_WAKE_FLAG: rd_mux = st.wflag;
			intr_pkg::ADDR_WAKE_EDGE: rd_mux = st.wedge;
			intr_pkg::ADDR_EXT_EDGE: rd_mux = {3'h0, st.eedge};
			intr_pkg::ADDR_CCR: rd_mux = {st.i_bit, ccr_flags};
			default: rd_mux = '0;
		endcase
	end

	// ****************************************************
	// next state
	// ****************************************************
	always_comb
	begin
		nx = st;
		nx.stack_wr = 1'b0;
		nx.vector_rd = 1'b0;
		nx.fetch_rd = 1'b0;
		nx.handler_start = 1'b0;
		if (reg_rd)
			nx.rdata = rd_mux;
		if (reg_wr && reg_addr == intr_pkg::ADDR_IEN1)
			nx.ien1 = reg_wdata;
		if (reg_wr && reg_addr == intr_pkg::ADDR_IEN2)
			nx.ien2 = reg_wdata;
		if (reg_wr && reg_addr == intr_pkg::ADDR_WAKE_EDGE)
			nx.wedge = reg_wdata;
		if (reg_wr && reg_addr == intr_pkg::ADDR_EXT_EDGE)
			nx.eedge = reg_wdata[4:0];
		if (reg_wr && reg_addr == intr_pkg::ADDR_CCR)
			nx.i_bit = reg_wdata[intr_pkg::CCR_I_BIT];
		// write 0 clears, write 1 keeps
		nx.int_req_reg1 = st.int_req_reg1 & (wr_int_req_reg1 ? reg_wdata : '1);
		nx.int_req_reg2 = st.int_req_reg2 & (wr_int_req_reg2 ? reg_wdata : '1);
		nx.wflag = st.wflag & (wr_wflag ? reg_wdata : '1);
		nx.int_req_reg1[intr_pkg::INT_REQ_REG1_ONE_BIT] = 1'b0;
		// reserved bit of the second request register is plain storage
		if (wr_int_req_reg2)
			nx.int_req_reg2[5] = reg_wdata[5];
		// an arriving request beats a same cycle clear
		nx.int_req_reg1 = nx.int_req_reg1 | int_req_reg1_set;
		nx.int_req_reg2 = nx.int_req_reg2 | int_req_reg2_set;
		// wakeup flags from the selected edge
		nx.wflag = nx.wflag | wake_set;
		case (st.seq)
			intr_pkg::ST_IDLE:
			begin
				if (accept)
				begin
					nx.seq = intr_pkg::ST_STACK;
					nx.cnt = intr_pkg::STACK_STATES - 4'h1;
					nx.vec = prio_vec;
					nx.saved_ccr = {st.i_bit, ccr_flags};
					nx.stack_wr = 1'b1;
					nx.stack_data = next_pc;
					nx.i_bit = 1'b1;
				end
			end
			intr_pkg::ST_STACK:
			begin
				// condition code pushed as a word
				if (st.cnt == intr_pkg::CCR_PUSH_CNT)
				begin
					nx.stack_wr = 1'b1;
					nx.stack_data = {st.saved_ccr, st.saved_ccr};
				end
				if (st.cnt == '0)
				begin
					// vectors are words, two bytes apart
					nx.seq = intr_pkg::ST_VECT;
					nx.cnt = intr_pkg::VFETCH_STATES - 4'h1;
					nx.vector_rd = 1'b1;
					nx.vector_addr = 16'({st.vec, 1'b0});
				end
				else
					nx.cnt = st.cnt - 4'h1;
			end
			intr_pkg::ST_VECT:
			begin
				if (st.cnt == '0)
				begin
					// handler start taken from the vector
					nx.seq = intr_pkg::ST_FETCH;
					nx.cnt = intr_pkg::IFETCH_STATES - 4'h1;
					nx.fetch_rd = 1'b1;
					nx.fetch_addr = vector_data;
				end
				else
					nx.cnt = st.cnt - 4'h1;
			end
			intr_pkg::ST_FETCH:
			begin
				if (st.cnt == '0)
				begin
					nx.seq = intr_pkg::ST_IDLE;
					nx.handler_start = 1'b1;
				end
				else
					nx.cnt = st.cnt - 4'h1;
			end
			default: nx.seq = intr_pkg::ST_IDLE;
		endcase
	end

	// every field, edge selects included, resets to zero
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			st <= '0;
			st.wedge <= intr_pkg::WAKE_EDGE_RST;
		end
		else
			st <= nx;
	end

	assign reg_rdata = st.rdata;
	assign cpu_mask = st.i_bit;
	assign stack_wr = st.stack_wr;
	assign stack_data = st.stack_data;
	assign vector_rd = st.vector_rd;
	assign vector_addr = st.vector_addr;
	assign fetch_rd = st.fetch_rd;
	assign fetch_addr = st.fetch_addr;
	assign handler_start = st.handler_start;
	assign accept_vector = st.vec;

	// ****************************************************
	// assertions
	// ****************************************************
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);

	sequence s_stack;
		(st.seq == intr_pkg::ST_STACK)[*4];
	endsequence
	sequence s_vect;
		(st.seq == intr_pkg::ST_VECT)[*2];
	endsequence
	sequence s_fetch;
		(st.seq == intr_pkg::ST_FETCH)[*4];
	endsequence

	chk_tc_wrap_flag: assert property (
		(tc_up || tc_down) && st.ien2[intr_pkg::INT_REQ_REG2_TC_BIT]
		|=> st.int_req_reg2[intr_pkg::INT_REQ_REG2_TC_BIT])
		else $error("timer C wrap did not set its flag");
	chk_ec_low_mode: assert property (
		ecl_up && event_ctr_16bit && !ech_up
		&& !st.int_req_reg2[intr_pkg::INT_REQ_REG2_EC_BIT] && !reg_wr
		|=> !st.int_req_reg2[intr_pkg::INT_REQ_REG2_EC_BIT])
		else $error("low byte overflow set flag in 16-bit mode");
	chk_flag_kept: assert property (
		st.int_req_reg1[0] && !wr_int_req_reg1 |=> st.int_req_reg1[0])
		else $error("request flag dropped without a write");
	chk_wake_flag: assert property (
		wake_edge[0] && wakeup_pin_func[0]
		&& st.ien1[intr_pkg::IEN1_WAKE_BIT] |=> st.wflag[0])
		else $error("wakeup edge did not set its flag");
	chk_ext_gate: assert property (
		!st.ien1[2] && !st.int_req_reg1[2] && !wr_int_req_reg1
		|=> !st.int_req_reg1[2])
		else $error("disabled external request set its flag");
	chk_mask_holds: assert property (
		st.i_bit && st.seq == intr_pkg::ST_IDLE
		|=> st.seq == intr_pkg::ST_IDLE)
		else $error("request accepted while masked");
	chk_accept_mask: assert property (
		accept |=> st.i_bit && st.stack_wr
		&& st.stack_data == $past(next_pc))
		else $error("acceptance missed mask or PC push");
	chk_prio_pick: assert property (
		accept && pend[0] |=> st.vec == intr_pkg::VEC_EXT_BASE)
		else $error("pin 0 request lost priority");
	chk_seq_timing: assert property (
		accept |=> s_stack ##1 s_vect ##1 s_fetch ##1 handler_start)
		else $error("acceptance sequence length wrong");
endmodule

// *** test/cpu_side_model.sv ***
// ****************************************************
// vector table memory seen from the cpu side
// ****************************************************
module cpu_side_model (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic vector_rd,
	input wire logic [15:0] vector_addr,
	output logic [15:0] vector_data
);
	timeunit 1ns;
	timeprecision 100ps;

	logic rd_q;
	logic [15:0] last;

	// read window spans the strobe cycle and the one after it
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			rd_q <= 1'b0;
			last <= 16'h0000;
		end
		else
		begin
			rd_q <= vector_rd;
			last <= vector_data;
		end
	end

	// handler address table
	// outside the window the bus toggles each cycle, so a sample one cycle late reads the inverted value
	assign vector_data = (vector_rd | rd_q) ? (16'h4000 | vector_addr) : ~last;
endmodule

// *** test/testbench.sv ***
// ****************************************************
// interrupt controller bench with a reference image
// ****************************************************
module testbench;
	timeunit 1ns;
	timeprecision 100ps;

	logic sys_clk, sys_rst, reg_wr, reg_rd, event_ctr_16bit, instr_done;
	logic cpu_mask, stack_wr, vector_rd, fetch_rd, handler_start;
	logic [2:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, wakeup_pin, wakeup_pin_func;
	logic [7:0] timer_c_count, event_ctr_high, event_ctr_low, wsel;
	logic [4:0] ext_req_pin, ext_pin_func, accept_vector, esel;
	logic [6:0] periph_req, ccr_flags;
	logic [15:0] next_pc, vector_data, stack_data, vector_addr, fetch_addr;
	logic [31:0] seed = 32'h0000000B;
	logic [31:0] r;
	int errors, num_checks, wr_count, accepts, v;
	// reference image: ien holds enable2 in the upper byte
	int int_req_reg1 = 'h20, int_req_reg2, wake, ien;
	int pmap[7] = '{10, 11, 12, 14, 15, 6, 7};
	int tcs[4] = '{'hFF, 'h05, 'hFF, 'h00};
	int tce[4] = '{1, 0, 0, 1};
	// mode, high byte, low byte, expected flag
	int ev[8] = '{'h100FF0, 'h100000, 'h1FF000, 'h100001,
		'h000FF0, 'h000001, 'h0FF000, 'h000001};

	intr_ctrl intr_ctrl_i (.*);
	cpu_side_model cpu_side_model_i (.*);

	initial
	begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	// instructions complete every other cycle; count stacked words
	always @(posedge sys_clk)
	begin
		instr_done <= ~instr_done;
		if (stack_wr === 1'b1)
			wr_count++;
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// bit position of a vector in {request2, request1}
	function automatic int pos(input int n);
		case (n)
			10: return 15;
			11: return 7;
			12: return 6;
			13: return 9;
			14: return 8;
			15: return 10;
			16: return 11;
			17: return 12;
			18: return 14;
			default: return n - 4;
		endcase
	endfunction

	// lowest pending vector wins, zero when nothing is pending
	function automatic int pick();
		for (int n = 4; n <= 18; n++)
		begin
			if (n == 9 && wake != 0 && ien[5])
				return n;
			if (n != 9 && (((int_req_reg1 | int_req_reg2 << 8) & ien) >> pos(n)) & 1)
				return n;
		end
		return 0;
	endfunction

	task automatic print_verdict();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [23:0] seen,
		input logic [23:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		case (a)
			intr_pkg::ADDR_IEN1: ien = (ien & 'hFF00) | int'(d);
			intr_pkg::ADDR_IEN2: ien = (ien & 'hFF) | (int'(d) << 8);
			intr_pkg::ADDR_INT_REQ_REG1: int_req_reg1 = int_req_reg1 & (int'(d) | 'h20);
			intr_pkg::ADDR_INT_REQ_REG2: int_req_reg2 = (int_req_reg2 & int'(d) & 'hDF) | (d & 'h20);
			intr_pkg::ADDR_WAKE_FLAG: wake = wake & int'(d);
			default: ;
		endcase
	endtask

	task automatic rd(input logic [2:0] a, input int exp, input string what);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		check(what, {16'h0000, reg_rdata}, 24'(exp & 'hFF));
	endtask

	task automatic pulse(input logic [6:0] m);
		@(posedge sys_clk);
		periph_req <= m;
		@(posedge sys_clk);
		periph_req <= 7'h00;
	endtask

	// unmask, then check the entry sequence at the PC push, condition code push, vector read, fetch and handler start
	task automatic accept(input int n);
		logic [7:0] c8;
		int k;
		wr(intr_pkg::ADDR_CCR, 8'h00);
		c8 = {1'b0, ccr_flags};
		k = 0;
		do
		begin
			@(posedge sys_clk);
			#1;
			k++;
		end
		while (stack_wr !== 1'b1 && k < 60);
		check("return pc", {7'h00, stack_wr, stack_data}, {8'h01, next_pc});
		if (stack_wr !== 1'b1)
			print_verdict();
		check("mask set", {23'h0, cpu_mask}, 24'h1);
		cyc(2);
		#1;
		check("ccr word", {7'h00, stack_wr, stack_data}, {8'h01, c8, c8});
		cyc(2);
		#1;
		check("vector", {7'h00, vector_rd, vector_addr}, 24'(n * 2 + 'h10000));
		cyc(2);
		#1;
		check("fetch", {7'h00, fetch_rd, fetch_addr}, 24'(n * 2 + 'h14000));
		cyc(4);
		#1;
		check("vector number", {handler_start, accept_vector}, 24'(n + 32));
		accepts++;
	endtask

	task automatic clear_src(input int n);
		int p;
		p = pos(n);
		if (n == 9)
			wr(intr_pkg::ADDR_WAKE_FLAG, 8'h00);
		else if (p < 8)
			wr(intr_pkg::ADDR_INT_REQ_REG1, ~(8'h01 << p));
		else
			wr(intr_pkg::ADDR_INT_REQ_REG2, ~(8'h01 << (p - 8)));
	endtask

	// ****************************************************
	// main sequence
	// ****************************************************
	initial
	begin
		sys_rst = 1'b1;
		{reg_wr, reg_rd, reg_addr, reg_wdata, periph_req} = '0;
		{timer_c_count, event_ctr_high, event_ctr_low, instr_done} = '0;
		{next_pc, ccr_flags} = '0;
		event_ctr_16bit = 1'b1;
		wakeup_pin = 8'hFF;
		ext_req_pin = 5'h1F;
		ext_pin_func = 5'h1F;
		r = rnd();
		wakeup_pin_func = r[7:0];
		cyc(10);
		sys_rst <= 1'b0;
		cyc(4);
		for (int a = 0; a < 7; a++)
			rd(3'(a), (a == 2) ? 'h20 : 0, "reset value");
		wr(intr_pkg::ADDR_CCR, 8'h80);
		pulse(7'h7F);
		cyc(2);
		rd(intr_pkg::ADDR_INT_REQ_REG1, int_req_reg1, "lost request1");
		rd(intr_pkg::ADDR_INT_REQ_REG2, int_req_reg2, "lost request2");
		wr(intr_pkg::ADDR_IEN1, 8'hEF);
		wr(intr_pkg::ADDR_IEN2, 8'hDF);
		pulse(7'h7F);
		for (int k = 0; k < 7; k++)
			if (pmap[k] < 8) int_req_reg1 |= 1 << pmap[k];
			else int_req_reg2 |= 1 << (pmap[k] - 8);
		cyc(2);
		rd(intr_pkg::ADDR_INT_REQ_REG1, int_req_reg1, "internal request1");
		wr(intr_pkg::ADDR_INT_REQ_REG2, 8'hFF);
		rd(intr_pkg::ADDR_INT_REQ_REG2, int_req_reg2, "write one kept");
		for (int i = 0; i < 4; i++)
		begin
			timer_c_count <= tcs[i][7:0];
			cyc(4);
			int_req_reg2 |= tce[i] << 1;
			rd(intr_pkg::ADDR_INT_REQ_REG2, int_req_reg2, "timer wrap");
			wr(intr_pkg::ADDR_INT_REQ_REG2, 8'hFC);
		end
		for (int i = 0; i < 8; i++)
		begin
			event_ctr_16bit <= ev[i][20];
			event_ctr_high <= ev[i][19:12];
			event_ctr_low <= ev[i][11:4];
			cyc(4);
			int_req_reg2 |= ev[i] & 1;
			rd(intr_pkg::ADDR_INT_REQ_REG2, int_req_reg2, "event overflow");
			wr(intr_pkg::ADDR_INT_REQ_REG2, 8'hFC);
		end
		r = rnd();
		esel = r[4:0];
		wr(intr_pkg::ADDR_EXT_EDGE, {3'h0, esel});
		for (int i = 0; i < 5; i++)
		begin
			ext_req_pin[i] <= ~esel[i];
			cyc(6);
			ext_req_pin[i] <= esel[i];
			cyc(6);
			int_req_reg1 |= ien & (1 << i);
		end
		rd(intr_pkg::ADDR_INT_REQ_REG1, int_req_reg1, "pin request");
		wsel = r[15:8];
		wr(intr_pkg::ADDR_WAKE_EDGE, wsel);
		rd(intr_pkg::ADDR_WAKE_EDGE, wsel, "wake edge");
		wakeup_pin <= ~wsel;
		cyc(6);
		wakeup_pin <= wsel;
		cyc(6);
		wake = wakeup_pin_func;
		rd(intr_pkg::ADDR_WAKE_FLAG, wake, "wake flags");
		check("masked stacking", 24'(wr_count), 24'h0);
		v = pick();
		while (v != 0 && accepts < 20)
		begin
			r = rnd();
			ccr_flags <= r[6:0];
			next_pc <= r[31:16];
			accept(v);
			clear_src(v);
			v = pick();
		end
		check("stacked words", 24'(wr_count), 24'(accepts * 2));
		rd(intr_pkg::ADDR_INT_REQ_REG1, int_req_reg1, "flags cleared");
		wr(intr_pkg::ADDR_IEN1, 8'hDF);
		wakeup_pin <= ~wsel;
		cyc(6);
		wakeup_pin <= wsel;
		cyc(6);
		rd(intr_pkg::ADDR_WAKE_FLAG, wake, "group disabled");
		print_verdict();
	end
endmodule
